/* hw/led_flash_sink_control.sv */
// control of the second current sink: led and flash modes behind an axi4-lite slave
// Operation
// - bit 15 of the flash control register picks steady led (0) or timed flash (1) operation.
// - in flash operation bit 14 picks the drive bit (0) or the flash pin (1) as trigger.
// - in led operation the drive bit (bit 13) turns the sink on when 1 and off when 0.
// - with register triggering a 0-to-1 drive bit starts a flash and hardware clears it at the end.
// - with pin triggering, writes to the drive bit do not affect the sink.
// - bit 12 picks one flash per trigger (0) or a self-triggered flash every 4 seconds (1).
// - bits 9:8 set the flash length to 32, 64, 96 or 1024 ms.
// - in led operation the fall (5:4) and rise (1:0) ramps are instant, 0.25 s, 0.5 s or 1 s.
// - in flash operation the same ramps are instant, 1.95 ms, 3.91 ms or 7.8 ms.
// - the power state machine reset returns every control field to zero.
// - bit 15 of the driver register enables the sink when 1 and disables it when 0.
// - bit 12 of the driver register forces the sink off in hibernate (0) or keeps it (1).
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module led_flash_sink_control #(
  parameter int unsigned REPEAT_CYCLES       = sink_b_pkg::REPEAT_CYCLES,
  parameter int unsigned FLASH_0_CYCLES      = sink_b_pkg::FLASH_0_CYCLES,
  parameter int unsigned FLASH_1_CYCLES      = sink_b_pkg::FLASH_1_CYCLES,
  parameter int unsigned FLASH_2_CYCLES      = sink_b_pkg::FLASH_2_CYCLES,
  parameter int unsigned FLASH_3_CYCLES      = sink_b_pkg::FLASH_3_CYCLES,
  parameter int unsigned LED_RAMP_1_CYCLES   = sink_b_pkg::LED_RAMP_1_CYCLES,
  parameter int unsigned LED_RAMP_2_CYCLES   = sink_b_pkg::LED_RAMP_2_CYCLES,
  parameter int unsigned LED_RAMP_3_CYCLES   = sink_b_pkg::LED_RAMP_3_CYCLES,
  parameter int unsigned FLASH_RAMP_1_CYCLES = sink_b_pkg::FLASH_RAMP_1_CYCLES,
  parameter int unsigned FLASH_RAMP_2_CYCLES = sink_b_pkg::FLASH_RAMP_2_CYCLES,
  parameter int unsigned FLASH_RAMP_3_CYCLES = sink_b_pkg::FLASH_RAMP_3_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        state_machine_reset,
  input  wire logic        hibernate,
  input  wire logic        flash_pin,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sink_b_output_pin,
  output logic [7:0]       sink_b_level,
  output logic [5:0]       sink_b_current_code
);

  logic [15:0] control;
  logic [15:0] driver;
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic        write_control;
  logic        write_driver;
  logic [15:0] lane_mask;
  logic [15:0] next_control;
  logic [15:0] next_driver;
  logic        pin_rise;
  logic        drive_rise;
  logic        trigger;
  logic        flash_done;
  logic        repeat_fire;
  logic [31:0] flash_count;
  logic [31:0] flash_cycles;
  logic [31:0] repeat_count;
  logic [31:0] rise_cycles;
  logic [31:0] fall_cycles;
  logic        target_on;
  logic        clear_all;
  logic [7:0]  ramp_level;

  sink_b_pkg::flash_state_type flash_state;

  wire logic function_select = control[sink_b_pkg::FUNCTION_SELECT_BIT];
  wire logic trigger_source  = control[sink_b_pkg::TRIGGER_SOURCE_BIT];
  wire logic drive_bit       = control[sink_b_pkg::DRIVE_BIT];
  wire logic repeat_select   = control[sink_b_pkg::REPEAT_SELECT_BIT];
  wire logic [1:0] flash_length = control[sink_b_pkg::FLASH_LENGTH_LSB +: 2];
  wire logic [1:0] fall_ramp    = control[sink_b_pkg::FALL_RAMP_LSB +: 2];
  wire logic [1:0] rise_ramp    = control[sink_b_pkg::RISE_RAMP_LSB +: 2];
  wire logic master_enable  = driver[sink_b_pkg::MASTER_ENABLE_BIT];
  wire logic hibernate_keep = driver[sink_b_pkg::HIBERNATE_KEEP_BIT];

  assign clear_all = !aresetn || state_machine_reset;

  // axi4-lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign write_control = do_write && aw_addr[11:2] == sink_b_pkg::CONTROL_ADDR[11:2];
  assign write_driver  = do_write && aw_addr[11:2] == sink_b_pkg::DRIVER_ADDR[11:2];
  assign lane_mask     = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sink_b_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (write_control || write_driver) ? sink_b_pkg::RESP_OKAY
                                                      : sink_b_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= sink_b_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= sink_b_pkg::RESP_OKAY;
      case (s_axi_araddr[11:2])
        sink_b_pkg::CONTROL_ADDR[11:2]: begin
          s_axi_rdata <= {16'h0000, control};
        end
        sink_b_pkg::DRIVER_ADDR[11:2]: begin
          s_axi_rdata <= {16'h0000, driver};
        end
        sink_b_pkg::STATUS_ADDR[11:2]: begin
          s_axi_rdata <= {16'h0000, ramp_level, 6'h00, sink_b_output_pin,
                          flash_state == sink_b_pkg::flash_active};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= sink_b_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // registers
  always_comb begin
    next_control = control;
    if (write_control) begin
      next_control = (control & ~(lane_mask & sink_b_pkg::CONTROL_WRITE_MASK))
                   | (w_data[15:0] & lane_mask & sink_b_pkg::CONTROL_WRITE_MASK);
    end
  end

  // a software write of the drive bit wins over the hardware clear
  always_ff @(posedge aclk) begin
    if (clear_all) begin
      control <= sink_b_pkg::CONTROL_RESET;
    end else if (flash_done && !trigger_source && !write_control) begin
      control <= control & ~(16'h0001 << sink_b_pkg::DRIVE_BIT);
    end else begin
      control <= next_control;
    end
  end

  always_comb begin
    next_driver = driver;
    if (write_driver) begin
      next_driver = (driver & ~(lane_mask & sink_b_pkg::DRIVER_WRITE_MASK))
                  | (w_data[15:0] & lane_mask & sink_b_pkg::DRIVER_WRITE_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (clear_all) begin
      driver <= sink_b_pkg::DRIVER_RESET;
    end else begin
      driver <= next_driver;
    end
  end

  // triggers
  pin_edge_sync u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (flash_pin),
    .pin_rise (pin_rise)
  );

  // registered so that mode bits written together with the drive bit apply to it
  always_ff @(posedge aclk) begin
    if (clear_all) begin
      drive_rise <= 1'b0;
    end else begin
      drive_rise <= write_control && !drive_bit && next_control[sink_b_pkg::DRIVE_BIT]
                 && !next_control[sink_b_pkg::TRIGGER_SOURCE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (clear_all || !function_select || !repeat_select) begin
      repeat_count <= 32'h0;
    end else if (repeat_count + 32'h1 >= REPEAT_CYCLES) begin
      repeat_count <= 32'h0;
    end else begin
      repeat_count <= repeat_count + 32'h1;
    end
  end

  assign repeat_fire = function_select && repeat_select
                    && repeat_count + 32'h1 >= REPEAT_CYCLES;

  assign trigger = function_select
                && ((trigger_source ? pin_rise : drive_rise) || repeat_fire);

  always_comb begin
    case (flash_length)
      2'b00:   flash_cycles = FLASH_0_CYCLES;
      2'b01:   flash_cycles = FLASH_1_CYCLES;
      2'b10:   flash_cycles = FLASH_2_CYCLES;
      default: flash_cycles = FLASH_3_CYCLES;
    endcase
  end

  // flash sequencer
  assign flash_done = flash_state == sink_b_pkg::flash_active
                   && flash_count + 32'h1 >= flash_cycles;

  always_ff @(posedge aclk) begin
    if (clear_all || !function_select) begin
      flash_state <= sink_b_pkg::flash_idle;
      flash_count <= 32'h0;
    end else begin
      case (flash_state)
        sink_b_pkg::flash_idle: begin
          flash_count <= 32'h0;
          if (trigger) begin
            flash_state <= sink_b_pkg::flash_active;
          end
        end
        sink_b_pkg::flash_active: begin
          // new triggers are ignored until the flash ends
          if (flash_done) begin
            flash_state <= sink_b_pkg::flash_idle;
            flash_count <= 32'h0;
          end else begin
            flash_count <= flash_count + 32'h1;
          end
        end
        default: begin
          flash_state <= sink_b_pkg::flash_idle;
          flash_count <= 32'h0;
        end
      endcase
    end
  end

  // ramp timing
  function automatic logic [31:0] ramp_time(input logic [1:0] sel, input logic flash);
    logic [31:0] cycles;
    cycles = 32'h0;
    case (sel)
      2'b01:   cycles = flash ? FLASH_RAMP_1_CYCLES : LED_RAMP_1_CYCLES;
      2'b10:   cycles = flash ? FLASH_RAMP_2_CYCLES : LED_RAMP_2_CYCLES;
      2'b11:   cycles = flash ? FLASH_RAMP_3_CYCLES : LED_RAMP_3_CYCLES;
      default: cycles = 32'h0;
    endcase
    return cycles;
  endfunction

  assign rise_cycles = ramp_time(rise_ramp, function_select);
  assign fall_cycles = ramp_time(fall_ramp, function_select);

  // sink drive
  always_comb begin
    target_on = 1'b0;
    if (master_enable && (hibernate_keep || !hibernate)) begin
      if (function_select) begin
        target_on = flash_state == sink_b_pkg::flash_active;
      end else begin
        target_on = drive_bit;
      end
    end
  end

  sink_ramp u_ramp (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .clear       (state_machine_reset),
    .target_on   (target_on),
    .rise_cycles (rise_cycles),
    .fall_cycles (fall_cycles),
    .level       (ramp_level)
  );

  always_ff @(posedge aclk) begin
    if (clear_all) begin
      sink_b_output_pin   <= 1'b0;
      sink_b_level        <= 8'h00;
      sink_b_current_code <= 6'h00;
    end else begin
      sink_b_output_pin   <= ramp_level != 8'h00;
      sink_b_level        <= ramp_level;
      sink_b_current_code <= driver[sink_b_pkg::CURRENT_CODE_LSB +: 6];
    end
  end

endmodule

/* hw/sink_b_pkg.sv */
// constants shared by the second current sink control logic
package sink_b_pkg;

  // clock rate and time conversion
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYCLES_PER_US = CLK_HZ / 1_000_000;

  // register indices as printed; the byte address is four times the index
  localparam logic [11:0] DRIVER_INDEX  = 12'h0AE;
  localparam logic [11:0] CONTROL_INDEX = 12'h0AF;
  localparam logic [11:0] STATUS_INDEX  = 12'h0C0;
  localparam logic [11:0] DRIVER_ADDR   = {DRIVER_INDEX[9:0], 2'b00};
  localparam logic [11:0] CONTROL_ADDR  = {CONTROL_INDEX[9:0], 2'b00};
  localparam logic [11:0] STATUS_ADDR   = {STATUS_INDEX[9:0], 2'b00};
  localparam int unsigned ADDR_WIDTH    = 12;

  // flash control register fields
  localparam int unsigned FUNCTION_SELECT_BIT = 15;
  localparam int unsigned TRIGGER_SOURCE_BIT  = 14;
  localparam int unsigned DRIVE_BIT           = 13;
  localparam int unsigned REPEAT_SELECT_BIT   = 12;
  localparam int unsigned FLASH_LENGTH_LSB    = 8;
  localparam int unsigned FALL_RAMP_LSB       = 4;
  localparam int unsigned RISE_RAMP_LSB       = 0;
  localparam logic [15:0] CONTROL_WRITE_MASK  = 16'hF333;
  localparam logic [15:0] CONTROL_RESET       = 16'h0000;

  // driver register fields
  localparam int unsigned MASTER_ENABLE_BIT  = 15;
  localparam int unsigned HIBERNATE_KEEP_BIT = 12;
  localparam int unsigned CURRENT_CODE_LSB   = 0;
  localparam logic [15:0] DRIVER_WRITE_MASK  = 16'h903F;
  localparam logic [15:0] DRIVER_RESET       = 16'h0000;

  // status register fields
  localparam int unsigned STATUS_FLASHING_BIT = 0;
  localparam int unsigned STATUS_SINK_ON_BIT  = 1;
  localparam int unsigned STATUS_LEVEL_LSB    = 8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // times in microseconds
  localparam int unsigned REPEAT_US    = 4_000_000;
  localparam int unsigned FLASH_0_US   = 32_000;
  localparam int unsigned FLASH_1_US   = 64_000;
  localparam int unsigned FLASH_2_US   = 96_000;
  localparam int unsigned FLASH_3_US   = 1_024_000;
  localparam int unsigned LED_RAMP_1_US   = 250_000;
  localparam int unsigned LED_RAMP_2_US   = 500_000;
  localparam int unsigned LED_RAMP_3_US   = 1_000_000;
  localparam int unsigned FLASH_RAMP_1_US = 1_950;
  localparam int unsigned FLASH_RAMP_2_US = 3_910;
  localparam int unsigned FLASH_RAMP_3_US = 7_800;

  // cycle counts derived from the times
  localparam int unsigned REPEAT_CYCLES       = REPEAT_US * CYCLES_PER_US;
  localparam int unsigned FLASH_0_CYCLES      = FLASH_0_US * CYCLES_PER_US;
  localparam int unsigned FLASH_1_CYCLES      = FLASH_1_US * CYCLES_PER_US;
  localparam int unsigned FLASH_2_CYCLES      = FLASH_2_US * CYCLES_PER_US;
  localparam int unsigned FLASH_3_CYCLES      = FLASH_3_US * CYCLES_PER_US;
  localparam int unsigned LED_RAMP_1_CYCLES   = LED_RAMP_1_US * CYCLES_PER_US;
  localparam int unsigned LED_RAMP_2_CYCLES   = LED_RAMP_2_US * CYCLES_PER_US;
  localparam int unsigned LED_RAMP_3_CYCLES   = LED_RAMP_3_US * CYCLES_PER_US;
  localparam int unsigned FLASH_RAMP_1_CYCLES = FLASH_RAMP_1_US * CYCLES_PER_US;
  localparam int unsigned FLASH_RAMP_2_CYCLES = FLASH_RAMP_2_US * CYCLES_PER_US;
  localparam int unsigned FLASH_RAMP_3_CYCLES = FLASH_RAMP_3_US * CYCLES_PER_US;

  // ramp level resolution
  localparam int unsigned LEVEL_WIDTH = 8;
  localparam int unsigned LEVEL_SHIFT = 8;

  typedef enum logic [1:0] {
    flash_idle,
    flash_active
  } flash_state_type;

endpackage

/* hw/pin_edge_sync.sv */
// two-stage synchroniser with rising edge detector for the flash pin
`timescale 1ns/1ps
module pin_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      pin_rise
);

  logic stage_a;
  logic stage_b;
  logic stage_b_old;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_a     <= 1'b0;
      stage_b     <= 1'b0;
      stage_b_old <= 1'b0;
      pin_rise    <= 1'b0;
    end else begin
      stage_a     <= pin_in;
      stage_b     <= stage_a;
      stage_b_old <= stage_b;
      pin_rise    <= stage_b & ~stage_b_old;
    end
  end

endmodule

/* hw/sink_ramp.sv */
// brightness ramp generator: steps a level toward full or zero
`timescale 1ns/1ps
module sink_ramp (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clear,
  input  wire logic        target_on,
  input  wire logic [31:0] rise_cycles,
  input  wire logic [31:0] fall_cycles,
  output logic [7:0]       level
);

  logic [31:0] interval;
  logic [31:0] tick_count;
  logic [7:0]  goal;

  // whole ramp spans 256 steps; zero interval means an instant change
  always_comb begin
    interval = target_on ? (rise_cycles >> sink_b_pkg::LEVEL_SHIFT)
                         : (fall_cycles >> sink_b_pkg::LEVEL_SHIFT);
    goal     = target_on ? 8'hFF : 8'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      level      <= 8'h00;
      tick_count <= 32'h0;
    end else if (level == goal || interval == 32'h0) begin
      level      <= goal;
      tick_count <= 32'h0;
    end else if (tick_count + 32'h1 >= interval) begin
      level      <= target_on ? level + 8'h01 : level - 8'h01;
      tick_count <= 32'h0;
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end

endmodule

/* testbench/led_flash_sink_control_monitor.sv */
// assertion checker for the second current sink control block
`timescale 1ns/1ps
module led_flash_sink_control_monitor (
  input logic        aclk,
  input logic        aresetn,
  input logic        state_machine_reset,
  input logic [11:0] s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        sink_b_output_pin,
  input logic [7:0]  sink_b_level,
  input logic [5:0]  sink_b_current_code
);
  logic       aw_bad;
  logic       ar_bad;
  logic [5:0] code_cap;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic logic unmapped(input logic [11:0] a);
    return a != sink_b_pkg::DRIVER_ADDR && a != sink_b_pkg::CONTROL_ADDR
      && a != sink_b_pkg::STATUS_ADDR;
  endfunction
  // remember whether the access in flight hits a hole in the map
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_bad <= 1'b0;
      ar_bad <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_bad <= unmapped(s_axi_awaddr);
      if (s_axi_arvalid && s_axi_arready) ar_bad <= unmapped(s_axi_araddr);
    end
  end
  always_ff @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) code_cap <= s_axi_wdata[5:0];
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_drv_write;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == sink_b_pkg::DRIVER_ADDR && s_axi_wvalid
      && s_axi_wready && s_axi_wstrb[0] && !state_machine_reset;
  endsequence
  property p_write_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  property p_read_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_bad_wr; s_axi_bvalid && aw_bad |-> s_axi_bresp == sink_b_pkg::RESP_SLVERR;
  endproperty
  property p_bad_rd; s_axi_rvalid && ar_bad |-> s_axi_rresp == sink_b_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0; endproperty
  property p_smr_clear; state_machine_reset |-> ##2 sink_b_level == 8'h00
    && sink_b_current_code == 6'h00; endproperty
  property p_code_follow; s_drv_write |-> ##[2:4] sink_b_current_code == code_cap; endproperty
  property p_pin_on; sink_b_level != 8'h00 [*2] |-> sink_b_output_pin; endproperty
  property p_pin_off; sink_b_level == 8'h00 [*2] |-> !sink_b_output_pin; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  a_b_stands: assert property (p_b_stands) else $error("write response dropped");
  a_r_stands: assert property (p_r_stands) else $error("read data dropped");
  a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
  a_bad_wr: assert property (p_bad_wr) else $error("hole write not refused");
  a_bad_rd: assert property (p_bad_rd) else $error("hole read not refused");
  a_smr_clear: assert property (p_smr_clear) else $error("outputs kept over reset");
  a_code_follow: assert property (p_code_follow) else $error("current code stale");
  a_pin_on: assert property (p_pin_on) else $error("pin low with level");
  a_pin_off: assert property (p_pin_off) else $error("pin high at zero level");
endmodule
bind led_flash_sink_control led_flash_sink_control_monitor mon (.*);

/* testbench/tb.sv */
// register level testbench for the second current sink control block
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] CTL = sink_b_pkg::CONTROL_ADDR;
  localparam logic [11:0] DRV = sink_b_pkg::DRIVER_ADDR;
  localparam int          FL[4] = '{20, 30, 40, 50};
  logic        aclk, aresetn, state_machine_reset, hibernate, flash_pin;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, last_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sink_b_output_pin, pin_prev;
  logic [7:0]  sink_b_level;
  logic [5:0]  sink_b_current_code;
  int          n_errors, samples_checked, cycle_count, pin_cycles, pin_rises, p0, r0;
  led_flash_sink_control #(.REPEAT_CYCLES(200), .FLASH_0_CYCLES(FL[0]),
    .FLASH_1_CYCLES(FL[1]), .FLASH_2_CYCLES(FL[2]), .FLASH_3_CYCLES(FL[3]),
    .LED_RAMP_1_CYCLES(512), .LED_RAMP_2_CYCLES(1024), .LED_RAMP_3_CYCLES(2048),
    .FLASH_RAMP_1_CYCLES(256), .FLASH_RAMP_2_CYCLES(512), .FLASH_RAMP_3_CYCLES(768)
  ) dut (.*);
  always #50 aclk = ~aclk;
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // pin activity counters and the hang guard
  always @(posedge aclk) begin
    cycle_count++;
    if (sink_b_output_pin === 1'b1) pin_cycles++;
    if (sink_b_output_pin === 1'b1 && pin_prev !== 1'b1) pin_rises++;
    pin_prev = sink_b_output_pin;
    if (cycle_count == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    last_data = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    {aclk, aresetn, state_machine_reset, hibernate, flash_pin, pin_prev} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'h3;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTL); chk("control reset", 32'h0, last_data);
    rd(DRV); chk("driver reset", 32'h0, last_data);
    s_axi_awprot <= 3'h2; s_axi_arprot <= 3'h2;
    rd(12'h010); chk("hole read resp", 32'h2, last_resp);
    wr(12'h010, 32'h1); chk("hole write resp", 32'h2, last_resp);
    wr(DRV, 32'hFFFF); rd(DRV); chk("driver bits", 32'h903F, last_data);
    s_axi_wstrb <= 4'h2; wr(DRV, 32'h0); rd(DRV); chk("driver lane", 32'h3F, last_data);
    s_axi_wstrb <= 4'h3; chk("current code", 32'h3F, sink_b_current_code);
    wr(DRV, 32'h8000); wr(CTL, 32'h2000); repeat (60) @(posedge aclk);
    chk("led on", 32'hFF, sink_b_level);
    rd(CTL); chk("led drive kept", 32'h2000, last_data);
    hibernate <= 1'b1; repeat (5) @(posedge aclk);
    chk("hibernate off", 32'h0, sink_b_output_pin);
    wr(DRV, 32'h9000); repeat (5) @(posedge aclk);
    chk("hibernate keep", 32'h1, sink_b_output_pin);
    hibernate <= 1'b0; wr(DRV, 32'h0000); repeat (5) @(posedge aclk);
    chk("sink disabled", 32'h0, sink_b_output_pin);
    wr(DRV, 32'h8000); wr(CTL, 32'h0000); repeat (5) @(posedge aclk);
    chk("led off", 32'h0, sink_b_level);
    wr(CTL, 32'h2001); repeat (100) @(posedge aclk);
    chk_rng("led rise ramp", 35, 60, sink_b_level);
    repeat (500) @(posedge aclk); chk("led ramp top", 32'hFF, sink_b_level);
    wr(CTL, 32'h0010); repeat (100) @(posedge aclk);
    chk_rng("led fall ramp", 195, 220, sink_b_level);
    wr(CTL, 32'hA301); repeat (30) @(posedge aclk);
    chk_rng("flash rise ramp", 20, 40, sink_b_level);
    repeat (60) @(posedge aclk); rd(CTL); chk("drive cleared", 32'h8301, last_data);
    for (int i = 0; i < 4; i++) begin
      wr(CTL, 32'h8000 | (i << 8)); p0 = pin_cycles;
      wr(CTL, 32'hA000 | (i << 8)); repeat (FL[i] + 20) @(posedge aclk);
      chk("flash length", FL[i], pin_cycles - p0);
      rd(CTL); chk("drive self clear", 32'h8000 | (i << 8), last_data);
    end
    wr(CTL, 32'hC000); r0 = pin_rises; wr(CTL, 32'hE000); repeat (40) @(posedge aclk);
    chk("drive in pin mode", 0, pin_rises - r0);
    p0 = pin_cycles;
    for (int k = 0; k < 2; k++) begin
      flash_pin <= 1'b1; repeat (3) @(posedge aclk);
      flash_pin <= 1'b0; repeat (5) @(posedge aclk);
    end
    repeat (40) @(posedge aclk);
    chk("pin flashes", 1, pin_rises - r0);
    chk("pin flash length", FL[0], pin_cycles - p0);
    wr(CTL, 32'h9000); r0 = pin_rises; repeat (450) @(posedge aclk);
    chk("repeat flashes", 2, pin_rises - r0);
    wr(CTL, 32'hF333); wr(DRV, 32'h903F);
    @(posedge aclk); state_machine_reset <= 1'b1;
    @(posedge aclk); state_machine_reset <= 1'b0;
    rd(CTL); chk("control after smr", 32'h0, last_data);
    rd(DRV); chk("driver after smr", 32'h0, last_data);
    results();
  end
endmodule
